// *** inc/acf_pkg.sv ***
// Constants and carrier types for the read address channel FIFO block
package acf_pkg;

  // ------------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------------
  localparam int ACF_AW = 4;
  localparam int ACF_DEPTH = 16;
  localparam int ACF_CW = ACF_AW + 1;
  localparam int ACF_TW = ACF_AW;
  localparam int ACF_ID_W = 4;
  localparam int ACF_ADDR_W = 32;
  localparam int ACF_USER_W = 1;
  localparam logic [ACF_CW-1:0] ACF_FULL_CNT = 5'h10;
  localparam logic [ACF_CW-1:0] ACF_ZERO_CNT = 5'h0;
  localparam logic [ACF_CW-1:0] ACF_ONE_CNT = 5'h1;
  localparam logic [ACF_AW-1:0] ACF_PTR_ONE = 4'h1;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam int ACF_PA_W = 8;
  localparam logic [ACF_PA_W-1:0] ACF_OFS_PF_THRESH = 8'h00;
  localparam logic [ACF_PA_W-1:0] ACF_OFS_PE_THRESH = 8'h04;
  localparam logic [ACF_PA_W-1:0] ACF_OFS_STATUS = 8'h08;
  localparam logic [ACF_PA_W-1:0] ACF_OFS_COUNTS = 8'h0C;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [ACF_TW-1:0] ACF_PF_THRESH_RST = 4'hE;
  localparam logic [ACF_TW-1:0] ACF_PE_THRESH_RST = 4'h2;
  localparam logic [31:0] ACF_WORD_ZERO = 32'h0000_0000;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int ACF_ST_PFULL = 0;
  localparam int ACF_ST_PEMPTY = 1;
  localparam int ACF_ST_FULL = 2;
  localparam int ACF_ST_EMPTY = 3;
  localparam int ACF_ST_UNDER_SEEN = 4;
  localparam int ACF_CNT_DATA_LSB = 0;
  localparam int ACF_CNT_WR_LSB = 8;
  localparam int ACF_CNT_RD_LSB = 16;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [ACF_ID_W-1:0] arid;
    logic [ACF_ADDR_W-1:0] araddr;
    logic [7:0] arlen;
    logic [2:0] arsize;
    logic [1:0] arburst;
    logic [1:0] arlock;
    logic [3:0] arcache;
    logic [2:0] arprot;
    logic [3:0] arqos;
    logic [3:0] arregion;
    logic [ACF_USER_W-1:0] aruser;
  } acf_ar_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ACF_PA_W-1:0] paddr;
    logic [31:0] pwdata;
  } acf_apb_req_t;

endpackage : acf_pkg

// *** hdl/acf_ar_fifo.sv ***
// Read address channel FIFO with counts, flags and an APB status port
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Write count tracks words written, width log2+1
// - Write count never underreports stored words
// - Accepted write shows at next write edge
// - Underflow pulses after read refused on empty
// - Refused read changes no contents or counts
// - Underflow may stay low; core blocks reads
// - Read count never overreports, width log2+1
// - Read shows in read count next edge
// - Common count gives stored words, width log2+1
// - Prog full set when count reaches threshold
// - Prog full clears below threshold
// - Prog empty set at or below threshold
// - Prog empty clears strictly above threshold
// - Address channel fields packed into data word
// - Valid and ready together write one entry
// - Burst length field is eight bits
// - Size three bits, burst type two bits
// - Cache four bits, protection three bits
// - QoS and region four bits each
// - Ready high only while FIFO not full
module acf_ar_fifo
  import acf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire acf_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire acf_ar_t s_axi_ar,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic rd_req,
  output acf_ar_t rd_data,
  output logic rd_valid,
  output logic [ACF_CW-1:0] wr_data_count,
  output logic [ACF_CW-1:0] rd_data_count,
  output logic [ACF_CW-1:0] data_count,
  output logic prog_full,
  output logic prog_empty,
  output logic underflow
);

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  acf_ar_t mem [ACF_DEPTH];
  logic [ACF_AW-1:0] wr_ptr;
  logic [ACF_AW-1:0] rd_ptr;
  logic [ACF_AW-1:0] next_wr_ptr;
  logic [ACF_AW-1:0] next_rd_ptr;
  logic [ACF_CW-1:0] next_count;
  logic next_arready;
  logic next_prog_full;
  logic next_prog_empty;
  logic next_underflow;
  logic next_rd_valid;
  acf_ar_t next_rd_data;
  logic push;
  logic pop;
  logic empty;

  // ------------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------------
  logic [ACF_TW-1:0] pf_thresh;
  logic [ACF_TW-1:0] pe_thresh;
  logic under_seen;
  logic [ACF_TW-1:0] next_pf_thresh;
  logic [ACF_TW-1:0] next_pe_thresh;
  logic next_under_seen;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic apb_access;
  logic apb_done;
  logic wr_hit;

  // ------------------------------------------------------------------
  // FIFO next state
  // ------------------------------------------------------------------
  // Ready is registered, so a push only ever lands while a slot is free
  assign push = s_axi_arvalid & s_axi_arready;
  assign empty = (data_count == ACF_ZERO_CNT);
  // A read on an empty FIFO is refused here and touches nothing
  assign pop = rd_req & ~empty;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = data_count;
    next_rd_data = rd_data;
    if (push) begin
      next_wr_ptr = wr_ptr + ACF_PTR_ONE;
    end
    if (pop) begin
      next_rd_ptr = rd_ptr + ACF_PTR_ONE;
      next_rd_data = mem[rd_ptr];
    end
    if (push && !pop) begin
      next_count = data_count + ACF_ONE_CNT;
    end else if (pop && !push) begin
      next_count = data_count - ACF_ONE_CNT;
    end
    next_rd_valid = pop;
    // Kept live rather than tied low: reports the refused read
    next_underflow = rd_req & empty;
    next_arready = (next_count != ACF_FULL_CNT);
    // Flags use the post-edge count and thresholds so they never lag
    next_prog_full = (next_count >= {1'b0, next_pf_thresh});
    next_prog_empty = (next_count <= {1'b0, next_pe_thresh});
  end

  // One clock: every count moves on the same edge, so none can
  // under- or over-report against the others
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      wr_data_count <= ACF_ZERO_CNT;
      rd_data_count <= ACF_ZERO_CNT;
      data_count <= ACF_ZERO_CNT;
      s_axi_arready <= 1'b0;
      prog_full <= 1'b0;
      prog_empty <= 1'b1;
      underflow <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else if (ce) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      wr_data_count <= next_count;
      rd_data_count <= next_count;
      data_count <= next_count;
      s_axi_arready <= next_arready;
      prog_full <= next_prog_full;
      prog_empty <= next_prog_empty;
      underflow <= next_underflow;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
    end
  end

  // Whole struct is one word: id, addr, len, size, burst, lock,
  // cache, prot, qos, region, user in that order, msb first
  always_ff @(posedge mclk) begin
    if (ce && push) begin
      mem[wr_ptr] <= s_axi_ar;
    end
  end

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  // One wait state: pready rises the cycle after penable
  assign apb_access = apb_req.psel & apb_req.penable;
  assign apb_done = apb_access & pready;
  assign wr_hit = apb_done & apb_req.pwrite;

  always_comb begin
    next_pf_thresh = pf_thresh;
    next_pe_thresh = pe_thresh;
    next_under_seen = under_seen;
    next_pready = apb_access & ~pready;
    next_prdata = ACF_WORD_ZERO;
    next_pslverr = 1'b0;
    if (wr_hit && apb_req.paddr == ACF_OFS_PF_THRESH) begin
      next_pf_thresh = apb_req.pwdata[ACF_TW-1:0];
    end
    if (wr_hit && apb_req.paddr == ACF_OFS_PE_THRESH) begin
      next_pe_thresh = apb_req.pwdata[ACF_TW-1:0];
    end
    if (wr_hit && apb_req.paddr == ACF_OFS_STATUS &&
        apb_req.pwdata[ACF_ST_UNDER_SEEN]) begin
      next_under_seen = 1'b0;
    end
    // Set after clear so a refused read in the clearing cycle survives
    if (next_underflow) begin
      next_under_seen = 1'b1;
    end
    if (apb_access && !pready) begin
      case (apb_req.paddr)
        ACF_OFS_PF_THRESH: begin
          next_prdata[ACF_TW-1:0] = pf_thresh;
        end
        ACF_OFS_PE_THRESH: begin
          next_prdata[ACF_TW-1:0] = pe_thresh;
        end
        ACF_OFS_STATUS: begin
          next_prdata[ACF_ST_PFULL] = prog_full;
          next_prdata[ACF_ST_PEMPTY] = prog_empty;
          // Taken from the count: ready is still low before the first
          // enabled edge after reset and would read back as full
          next_prdata[ACF_ST_FULL] = (data_count == ACF_FULL_CNT);
          next_prdata[ACF_ST_EMPTY] = empty;
          next_prdata[ACF_ST_UNDER_SEEN] = under_seen;
        end
        ACF_OFS_COUNTS: begin
          next_prdata[ACF_CNT_DATA_LSB +: ACF_CW] = data_count;
          next_prdata[ACF_CNT_WR_LSB +: ACF_CW] = wr_data_count;
          next_prdata[ACF_CNT_RD_LSB +: ACF_CW] = rd_data_count;
        end
        default: begin
          next_pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pf_thresh <= ACF_PF_THRESH_RST;
      pe_thresh <= ACF_PE_THRESH_RST;
      under_seen <= 1'b0;
      prdata <= ACF_WORD_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pf_thresh <= next_pf_thresh;
      pe_thresh <= next_pe_thresh;
      under_seen <= next_under_seen;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_push_count;
    ce && push && !pop |=> data_count == $past(data_count) + ACF_ONE_CNT;
  endproperty
  a_push_count: assert property (p_push_count)
    else $error("accepted write not counted at next edge");

  property p_pop_count;
    ce && pop && !push |=> rd_data_count == $past(rd_data_count) - ACF_ONE_CNT;
  endproperty
  a_pop_count: assert property (p_pop_count)
    else $error("read not reflected in read count");

  property p_counts_agree;
    wr_data_count == data_count && rd_data_count == data_count;
  endproperty
  a_counts_agree: assert property (p_counts_agree)
    else $error("side counts disagree with stored count");

  property p_underflow;
    ce && rd_req && empty |=> underflow && !rd_valid;
  endproperty
  a_underflow: assert property (p_underflow)
    else $error("refused read did not raise underflow");

  property p_underflow_harmless;
    ce && rd_req && empty && !push |=> data_count == ACF_ZERO_CNT
      && rd_ptr == $past(rd_ptr);
  endproperty
  a_underflow_harmless: assert property (p_underflow_harmless)
    else $error("refused read disturbed the FIFO");

  property p_ready_not_full;
    s_axi_arready |-> data_count != ACF_FULL_CNT;
  endproperty
  a_ready_not_full: assert property (p_ready_not_full)
    else $error("ready high while full");

  property p_prog_full;
    prog_full == (data_count >= {1'b0, pf_thresh});
  endproperty
  a_prog_full: assert property (p_prog_full)
    else $error("prog full wrong against threshold");

  property p_prog_empty;
    prog_empty == (data_count <= {1'b0, pe_thresh});
  endproperty
  a_prog_empty: assert property (p_prog_empty)
    else $error("prog empty wrong against threshold");

  property p_fill_full;
    ce && push && !pop && data_count == ACF_FULL_CNT - ACF_ONE_CNT
      |=> !s_axi_arready ##0 data_count == ACF_FULL_CNT;
  endproperty
  a_fill_full: assert property (p_fill_full)
    else $error("ready not dropped on last free slot");

  property p_apb_wait;
    ce && apb_access && !pready |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("APB answer missing after one wait state");

endmodule : acf_ar_fifo

`default_nettype wire

// *** sim/acf_ar_master.sv ***
// Upstream read address master model
`timescale 1ns/1ps
`default_nettype none
module acf_ar_master
  import acf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic send,
  input wire acf_ar_t word,
  input wire logic arready,
  output acf_ar_t ar,
  output logic arvalid
);
  // Released bus shows inverted bits so stale data never looks valid
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arvalid <= 1'b0;
      ar <= '0;
    end else if (!arvalid || (arready && ce)) begin
      arvalid <= send;
      ar <= send ? word : ~ar;
    end
  end
endmodule : acf_ar_master
`default_nettype wire

// *** sim/axi_channel_fifo_status_tb.sv ***
// Self-checking bench for the read address channel FIFO
`timescale 1ns/1ps
`default_nettype none
module axi_channel_fifo_status_tb
  import acf_pkg::*;
;
  logic mclk, rst, ce, send, rd_req, arvalid, arready, pready, pslverr;
  logic rd_valid, prog_full, prog_empty, underflow, err, push, pop;
  logic [31:0] prdata, rd;
  logic [ACF_CW-1:0] wr_data_count, rd_data_count, data_count;
  acf_apb_req_t req;
  acf_ar_t word, ar, rd_data, hd;
  acf_ar_t q[$];
  int mismatches, comparisons, seed, cnt = 0;
  int pf = ACF_PF_THRESH_RST;
  int pe = ACF_PE_THRESH_RST;
  logic uf = 1'b0, vld = 1'b0, up = 1'b0, seen = 1'b0;

  acf_ar_master u_acf_ar_master (.mclk(mclk), .rst(rst), .ce(ce),
    .send(send), .word(word), .arready(arready), .ar(ar),
    .arvalid(arvalid));
  acf_ar_fifo u_acf_ar_fifo (.mclk(mclk), .rst(rst), .ce(ce),
    .apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .s_axi_ar(ar), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid),
    .wr_data_count(wr_data_count), .rd_data_count(rd_data_count),
    .data_count(data_count), .prog_full(prog_full),
    .prog_empty(prog_empty), .underflow(underflow));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ------------------------------------------------------------------
  // Reference model and checks
  // ------------------------------------------------------------------
  // Model resets with the design so a mid-run reset stays in step
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt = 0;
      q.delete();
      up = 1'b0;
      uf = 1'b0;
      vld = 1'b0;
      seen = 1'b0;
      pf = ACF_PF_THRESH_RST;
      pe = ACF_PE_THRESH_RST;
    end else if (ce) begin
      push = arvalid && up && cnt != 16;
      pop = rd_req && cnt != 0;
      uf = rd_req && cnt == 0;
      seen = seen | uf;
      vld = pop;
      if (pop) hd = q.pop_front();
      if (push) q.push_back(ar);
      cnt = cnt + push - pop;
      up = 1'b1;
    end
  end

  task automatic chk(string what, logic [127:0] exp, logic [127:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  always @(negedge mclk) begin
    chk("data_count", cnt, data_count);
    chk("wr_data_count", cnt, wr_data_count);
    chk("rd_data_count", cnt, rd_data_count);
    chk("prog_full", cnt >= pf, prog_full);
    chk("prog_empty", cnt <= pe, prog_empty);
    chk("underflow", uf, underflow);
    chk("arready", up && cnt != 16, arready);
    chk("rd_valid", vld, rd_valid);
    if (vld) chk("rd_data", hd, rd_data);
  end

  function automatic logic [31:0] status_word();
    return {27'h0, seen, cnt == 0, cnt == 16, cnt <= pe, cnt >= pf};
  endfunction : status_word

  function automatic logic [31:0] counts_word();
    logic [4:0] c;
    c = cnt[4:0];
    return {11'h0, c, 3'h0, c, 3'h0, c};
  endfunction : counts_word

  // ------------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------------
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge mclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      mismatches++;
      $display("unexpected pready exp 1 got %b", pready);
    end
    rd = prdata;
    err = pslverr;
    req <= '0;
    if (w && !err && a == ACF_OFS_PF_THRESH) pf = d[3:0];
    if (w && !err && a == ACF_OFS_PE_THRESH) pe = d[3:0];
    if (w && !err && a == ACF_OFS_STATUS && d[4]) seen = 1'b0;
  endtask : apb

  task automatic reg_chk(logic [7:0] a, logic [31:0] exp, logic e);
    apb(1'b0, a, '0);
    chk("prdata", exp, rd);
    chk("pslverr", e, err);
  endtask : reg_chk

  // Random pushes and pops; ce dropouts stress the freeze path
  task automatic traffic(int n, int s, int r, logic rnd_ce);
    logic [95:0] rnd;
    repeat (n) begin
      @(posedge mclk);
      rnd = {$random(seed), $random(seed), $random(seed)};
      word <= rnd[$bits(acf_ar_t)-1:0];
      send <= ($random(seed) & 3) < s;
      rd_req <= ($random(seed) & 3) < r;
      ce <= rnd_ce ? (($random(seed) & 7) != 0) : 1'b1;
    end
    @(posedge mclk);
    send <= 1'b0;
    rd_req <= 1'b0;
    ce <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask : traffic

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (9000) @(posedge mclk);
    mismatches++;
    $display("unexpected run length exp done got timeout");
    report_and_stop();
  end

  initial begin
    seed = 37301;
    rst = 1'b1;
    ce = 1'b1;
    send = 1'b0;
    rd_req = 1'b0;
    word = '0;
    req = '0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    reg_chk(ACF_OFS_PF_THRESH, 32'h0000_000E, 1'b0);
    reg_chk(ACF_OFS_PE_THRESH, 32'h0000_0002, 1'b0);
    $display("test reset done");
    traffic(24, 4, 0, 1'b0);
    reg_chk(ACF_OFS_STATUS, status_word(), 1'b0);
    reg_chk(ACF_OFS_COUNTS, counts_word(), 1'b0);
    $display("test fill done");
    traffic(24, 0, 4, 1'b0);
    reg_chk(ACF_OFS_STATUS, status_word(), 1'b0);
    apb(1'b1, ACF_OFS_STATUS, 32'h0000_0010);
    reg_chk(ACF_OFS_STATUS, status_word(), 1'b0);
    reg_chk(8'h10, 32'h0000_0000, 1'b1);
    $display("test drain done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ACF_OFS_PF_THRESH, 32'(i * 5));
      apb(1'b1, ACF_OFS_PE_THRESH, 32'(15 - i * 5));
      traffic(400, 1 + i % 3, 1 + (i + 1) % 3, 1'b1);
      reg_chk(ACF_OFS_COUNTS, counts_word(), 1'b0);
      $display("test random %0d done", i);
    end
    // Reset in mid-run with data stored and thresholds moved
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    reg_chk(ACF_OFS_COUNTS, counts_word(), 1'b0);
    reg_chk(ACF_OFS_STATUS, status_word(), 1'b0);
    reg_chk(ACF_OFS_PF_THRESH, 32'h0000_000E, 1'b0);
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule : axi_channel_fifo_status_tb
`default_nettype wire
